// [lhp_host_port.sv]
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - latch bus mode straps and status pin at reset
// - pin roles follow latched mode until reset
// - sixteen bit data port, six selectable modes, transfers only in MODE_GEN1 and MODE_STROBE
// - latch endian and panel power polarity straps
// - generic mode transfers timed by host bus clock
// - generic mode writes only bytes whose strobes active
// - generic mode per byte read strobes, direction pin reused
// - wait held until data valid or accepted
// - strobe mode transfers timed by host bus clock
// - strobe mode uses address bits one to fifteen
// - strobe mode byte enables from bit zero, high strobe
// - strobe mode direction pin low write, high read
// - strobe mode address valid only under address strobe
// - variable wait states per access from arbitration
// - registers at top 32 bytes, buffer from base

module lhp_host_port (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lhp_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic host_bus_clock,
	input wire logic chip_select_n,
	input wire logic bus_status_strobe_n,
	input wire logic low_byte_write_strobe_n,
	input wire logic high_byte_write_strobe_n,
	input wire logic low_byte_read_strobe_n,
	input wire logic read_write_n,
	input wire logic [lhp_pkg::AW-1:0] host_addr,
	input wire logic [lhp_pkg::DW-1:0] host_data_in,
	output logic [lhp_pkg::DW-1:0] host_data_out,
	output logic host_data_oe_n,
	output logic host_wait_n,
	input wire logic [2:0] bus_mode_straps,
	input wire logic [1:0] endian_and_power_polarity_straps,
	output logic panel_power_control,
	output logic mem_req,
	output logic mem_we,
	output logic [14:0] mem_word_addr,
	output logic [1:0] mem_byte_en,
	output logic [lhp_pkg::DW-1:0] mem_wdata,
	output logic mem_reg_sel,
	input wire logic mem_ack,
	input wire logic [lhp_pkg::DW-1:0] mem_rdata
);
	import lhp_pkg::*;

	localparam int unsigned SW = 1 + 6 + AW + DW + 5;

	logic [SW-1:0] sync_in;
	logic [SW-1:0] sync_out;
	logic hclk_s, cs_s, bs_s, we0_s, we1_s, rd0_s, rdwr_s;
	logic [AW-1:0] addr_s;
	logic [DW-1:0] din_s;
	logic [2:0] mstrap_s;
	logic [1:0] xstrap_s;

	assign sync_in = {host_bus_clock, chip_select_n, bus_status_strobe_n,
		low_byte_write_strobe_n, high_byte_write_strobe_n, low_byte_read_strobe_n,
		read_write_n, host_addr, host_data_in, bus_mode_straps,
		endian_and_power_polarity_straps};

	lhp_sync #(.W(SW)) u_sync (
		.mclk(mclk),
		.d(sync_in),
		.q(sync_out)
	);

	assign {hclk_s, cs_s, bs_s, we0_s, we1_s, rd0_s, rdwr_s, addr_s, din_s, mstrap_s,
		xstrap_s} = sync_out;

	// strap capture
	lhp_mode_t mode_q;
	lhp_mode_t mode_dec;
	logic latch_pend_q;
	logic big_endian_q;
	logic pwr_high_q;

	assign mode_dec = (mstrap_s == STRAP_PROC_A) ? MODE_PROC_A :
		(mstrap_s == STRAP_PROC_B) ? MODE_PROC_B :
		(mstrap_s == STRAP_STROBE) ? MODE_STROBE :
		(mstrap_s == STRAP_MC2) ? MODE_MC2 :
		(mstrap_s == STRAP_GENERIC) ? (bs_s ? MODE_GEN2 : MODE_GEN1) :
		MODE_NONE;

	// straps are taken in the first cycle after release, so rst must span the sync delay
	always_ff @(posedge mclk) begin
		if (rst) begin
			latch_pend_q <= 1'b1;
			mode_q <= MODE_NONE;
			big_endian_q <= 1'b0;
			pwr_high_q <= 1'b0;
		end else if (latch_pend_q) begin
			latch_pend_q <= 1'b0;
			mode_q <= mode_dec;
			big_endian_q <= xstrap_s[0];
			pwr_high_q <= xstrap_s[1];
		end
	end

	// register file
	logic [1:0] ctrl_q;
	logic [15:0] xfer_cnt_q;
	logic [31:0] prdata_q;
	logic panel_pwr_q;
	logic apb_setup, apb_access, apb_wr;
	logic hit_ctrl, hit_status, hit_cnt, hit_any;
	logic [31:0] status_w;
	logic [31:0] rd_mux;

	assign apb_setup = psel & ~penable;
	assign apb_access = psel & penable;
	assign apb_wr = apb_access & pwrite;
	assign hit_ctrl = (paddr == OFS_CTRL);
	assign hit_status = (paddr == OFS_STATUS);
	assign hit_cnt = (paddr == OFS_XFER_CNT);
	assign hit_any = hit_ctrl | hit_status | hit_cnt;

	lhp_state_t state_q;
	lhp_state_t state_d;

	assign status_w = {21'h0, (state_q != ST_IDLE), pwr_high_q, big_endian_q, 1'b0, mode_q};
	assign rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
		hit_status ? status_w :
		hit_cnt ? {16'h0, xfer_cnt_q} : 32'h0;

	// registers answer at once; the register bus never sees a wait state
	assign pready = 1'b1;
	assign pslverr = apb_access & ~hit_any;
	assign prdata = prdata_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			prdata_q <= 32'h0;
			panel_pwr_q <= 1'b0;
		end else begin
			if (apb_wr && hit_ctrl) begin
				ctrl_q <= pwdata[1:0];
			end
			if (apb_setup) begin
				prdata_q <= rd_mux;
			end
			panel_pwr_q <= pwr_high_q ? ctrl_q[CTRL_PANEL_ON] : ~ctrl_q[CTRL_PANEL_ON];
		end
	end

	assign panel_power_control = panel_pwr_q;

	// host cycle decode
	logic hclk_q;
	logic hclk_rise;
	logic gen, stb, port_on, sel;
	logic gen_wr_lo, gen_wr_hi, gen_rd_lo, gen_rd_hi, gen_wr, gen_rd;
	logic stb_lo, stb_hi, stb_wr, stb_as;
	logic cycle_on, start_req, is_write_w;
	logic [1:0] be_raw, be_ord;
	logic [DW-1:0] wdata_ord, rdata_ord;

	assign hclk_rise = hclk_s & ~hclk_q;
	assign port_on = ctrl_q[CTRL_PORT_EN];
	assign gen = port_on & (mode_q == MODE_GEN1);
	assign stb = port_on & (mode_q == MODE_STROBE);
	assign sel = ~cs_s;

	assign gen_wr_lo = ~we0_s;
	assign gen_wr_hi = ~we1_s;
	assign gen_rd_lo = ~rd0_s;
	assign gen_rd_hi = ~rdwr_s;
	assign gen_wr = gen_wr_lo | gen_wr_hi;
	assign gen_rd = gen_rd_lo | gen_rd_hi;

	assign stb_lo = ~addr_s[0];
	assign stb_hi = ~we1_s;
	assign stb_wr = ~rdwr_s;
	assign stb_as = ~bs_s;

	assign cycle_on = sel & (gen ? (gen_wr | gen_rd) : stb ? stb_as : 1'b0);
	assign start_req = (state_q == ST_IDLE) & hclk_rise & sel &
		(gen ? (gen_wr | gen_rd) : stb ? (stb_as & (stb_lo | stb_hi)) : 1'b0);
	assign is_write_w = gen ? gen_wr : stb_wr;
	assign be_raw = gen ? (gen_wr ? {gen_wr_hi, gen_wr_lo} : {gen_rd_hi, gen_rd_lo}) :
		{stb_hi, stb_lo};
	// byte order swap is per strap, independent of the bus mode
	assign be_ord = big_endian_q ? {be_raw[0], be_raw[1]} : be_raw;
	assign wdata_ord = big_endian_q ? {din_s[7:0], din_s[15:8]} : din_s;
	assign rdata_ord = big_endian_q ? {mem_rdata[7:0], mem_rdata[15:8]} : mem_rdata;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start_req) begin
					state_d = ST_REQ;
				end
			end
			ST_REQ: begin
				if (mem_ack) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				if (!cycle_on) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	logic we_q, reg_sel_q;
	logic [1:0] be_q;
	logic [14:0] waddr_q;
	logic [DW-1:0] wdata_q, rdata_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			hclk_q <= 1'b0;
			we_q <= 1'b0;
			be_q <= 2'h0;
			waddr_q <= 15'h0;
			wdata_q <= 16'h0;
			reg_sel_q <= 1'b0;
			rdata_q <= 16'h0;
			xfer_cnt_q <= XFER_CNT_RESET;
		end else begin
			state_q <= state_d;
			hclk_q <= hclk_s;
			if (start_req) begin
				we_q <= is_write_w;
				be_q <= be_ord;
				waddr_q <= addr_s[15:1];
				wdata_q <= wdata_ord;
				reg_sel_q <= (addr_s[15:5] == REG_WIN);
			end
			if (state_q == ST_REQ && mem_ack) begin
				xfer_cnt_q <= xfer_cnt_q + 16'h1;
				if (!we_q) begin
					rdata_q <= rdata_ord;
				end
			end
		end
	end

	assign mem_req = (state_q == ST_REQ);
	assign mem_we = we_q;
	assign mem_byte_en = be_q;
	assign mem_word_addr = waddr_q;
	assign mem_wdata = wdata_q;
	assign mem_reg_sel = reg_sel_q;

	// wait goes low as soon as a cycle is seen and rises only once the access is done
	assign host_wait_n = ~(cycle_on & (state_q != ST_DONE));
	assign host_data_oe_n = ~((state_q == ST_DONE) & ~we_q & cycle_on);
	assign host_data_out = rdata_q;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence start_s;
		start_req;
	endsequence

	sequence pending_s;
		(state_q == ST_REQ) && !mem_ack;
	endsequence

	strap_latch_a: assert property ($fell(latch_pend_q) |-> mode_q == $past(mode_dec))
		else $error("bus mode not taken from straps");
	mode_hold_a: assert property (!latch_pend_q && !$past(latch_pend_q) |-> $stable(mode_q))
		else $error("bus mode changed after reset");
	strap_extra_a: assert property ($fell(latch_pend_q) |->
		big_endian_q == $past(xstrap_s[0]) && pwr_high_q == $past(xstrap_s[1]))
		else $error("endian or polarity strap not latched");
	clock_edge_a: assert property ((state_q == ST_IDLE) && !(hclk_s && !hclk_q) |=>
		state_q == ST_IDLE)
		else $error("transfer started without bus clock edge");
	gen_bytes_a: assert property (start_s and (gen && gen_wr && !big_endian_q) |=>
		mem_byte_en == {$past(gen_wr_hi), $past(gen_wr_lo)} && mem_we)
		else $error("generic write enables wrong");
	wait_hold_a: assert property (pending_s and cycle_on |-> !host_wait_n)
		else $error("wait released before access done");
	wait_release_a: assert property ((state_q == ST_REQ) && mem_ack |=>
		(state_q == ST_DONE) && (host_wait_n || !cycle_on))
		else $error("wait not released after ack");
	var_wait_a: assert property (pending_s |=> state_q == ST_REQ ##0 mem_req)
		else $error("request dropped before ack");
	word_addr_a: assert property (start_s |=> mem_word_addr == $past(addr_s[15:1]))
		else $error("word address wrong");
	stb_dir_a: assert property (start_s and stb |=>
		mem_we == !$past(rdwr_s) && mem_byte_en[0] == (big_endian_q ? $past(stb_hi) :
		$past(stb_lo)))
		else $error("strobe mode direction or enables wrong");
	as_gate_a: assert property (stb && bs_s && (state_q == ST_IDLE) |=> state_q == ST_IDLE)
		else $error("transfer without address strobe");
	reg_window_a: assert property (start_s |=>
		mem_reg_sel == ($past(addr_s[15:5]) == REG_WIN))
		else $error("register window decode wrong");
	read_drive_a: assert property ((state_q == ST_DONE) && !we_q && cycle_on |->
		!host_data_oe_n && host_wait_n)
		else $error("read data not driven");

	// the pins are only driven in the data phase of a read
	oe_quiet_a: assert property ((state_q != ST_DONE) |-> host_data_oe_n)
		else $error("data pins driven outside read phase");
	req_idle_a: assert property ((state_q == ST_IDLE) |-> !mem_req)
		else $error("back end request while idle");
	wait_idle_a: assert property (!cycle_on |-> host_wait_n)
		else $error("wait asserted with no host cycle");
	port_off_a: assert property (!gen && !stb && (state_q == ST_IDLE) |=>
		state_q == ST_IDLE)
		else $error("transfer in inactive mode");
	// the first edge after release still shows the reset value, so skip it
	panel_pol_a: assert property (!$past(rst) |-> panel_power_control ==
		($past(pwr_high_q) ? $past(ctrl_q[CTRL_PANEL_ON]) : !$past(ctrl_q[CTRL_PANEL_ON])))
		else $error("panel power polarity wrong");
	cnt_step_a: assert property ((state_q == ST_REQ) && mem_ack |=>
		xfer_cnt_q == $past(xfer_cnt_q) + 16'h1)
		else $error("transfer count not advanced");
endmodule // lhp_host_port

`default_nettype wire

// [lhp_pkg.sv]
`default_nettype none

package lhp_pkg;
	localparam int unsigned MCLK_HZ = 20_000_000;
	localparam int unsigned APB_AW = 8;
	localparam int unsigned DW = 16;
	localparam int unsigned AW = 16;

	localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] OFS_XFER_CNT = 8'h08;

	localparam int unsigned CTRL_PANEL_ON = 0;
	localparam int unsigned CTRL_PORT_EN = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	localparam int unsigned STAT_ENDIAN = 8;
	localparam int unsigned STAT_PWR_POL = 9;
	localparam int unsigned STAT_BUSY = 10;

	localparam logic [2:0] STRAP_PROC_A = 3'h0;
	localparam logic [2:0] STRAP_PROC_B = 3'h1;
	localparam logic [2:0] STRAP_STROBE = 3'h3;
	localparam logic [2:0] STRAP_MC2 = 3'h5;
	localparam logic [2:0] STRAP_GENERIC = 3'h7;

	// top 32 bytes of the 64K window hold the control registers
	localparam logic [10:0] REG_WIN = 11'h7FF;
	localparam logic [15:0] XFER_CNT_RESET = 16'h0000;

	typedef enum logic [6:0] {
		MODE_NONE = 7'h01,
		MODE_PROC_A = 7'h02,
		MODE_PROC_B = 7'h04,
		MODE_STROBE = 7'h08,
		MODE_MC2 = 7'h10,
		MODE_GEN1 = 7'h20,
		MODE_GEN2 = 7'h40
	} lhp_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_REQ = 3'h2,
		ST_DONE = 3'h4
	} lhp_state_t;
endpackage

`default_nettype wire

// [lhp_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module lhp_sync #(
	parameter int unsigned W = 1
) (
	input wire logic mclk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	// plain two-stage chain; no reset so strap values flow through during reset
	always_ff @(posedge mclk) begin
		s1_q <= d;
		s2_q <= s1_q;
	end

	assign q = s2_q;
endmodule // lhp_sync

`default_nettype wire

// [lhp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lhp_host_model (
	input wire logic mclk,
	output logic bclk,
	output logic cs_n,
	output logic bs_n,
	output logic we0_n,
	output logic we1_n,
	output logic rd0_n,
	output logic rw_n,
	output logic [15:0] addr,
	output logic [15:0] dout,
	input wire logic [15:0] din,
	input wire logic oe_n,
	input wire logic wait_n
);
	logic smode = 1'b0;
	logic hung = 1'b0;
	initial begin
		bclk = 1'b0;
		{cs_n, we0_n, we1_n, rd0_n, rw_n} = 5'h1F;
		bs_n = 1'b0;
		addr = 16'h0000;
		dout = 16'h0000;
	end
	// host system clock runs free at one eighth of the mclk rate, changing on mclk falling edges
	always #200 bclk = ~bclk;
	task automatic run(input logic wr, input logic [15:0] a, input logic [1:0] be,
		input logic [15:0] d, input logic as_on, output logic [15:0] q, output int wc);
		int k;
		@(posedge mclk);
		cs_n <= 1'b0;
		dout <= d;
		if (smode) begin
			addr <= {a[15:1], ~be[0]};
			{we0_n, rd0_n} <= 2'h3;
			we1_n <= ~be[1];
			rw_n <= ~wr;
			bs_n <= ~as_on;
		end else begin
			addr <= a;
			{we1_n, we0_n} <= ~(be & {2{wr}});
			{rw_n, rd0_n} <= ~(be & {2{~wr}});
		end
		k = 0;
		wc = 0;
		while (wait_n && k < 40) begin
			@(posedge mclk);
			k++;
		end
		// cycle ends when the device lets go of wait, after 400 cycles of wait, or if wait never falls within 40 cycles
		while (!wait_n && wc < 400) begin
			@(posedge mclk);
			wc++;
		end
		hung <= (wc == 400);
		q = oe_n ? 16'hXXXX : din;
		{cs_n, we0_n, we1_n, rd0_n, rw_n} <= 5'h1F;
		bs_n <= smode;
		// released lines must not keep their last value
		addr <= ~a;
		dout <= ~d;
		repeat (8) @(posedge mclk);
	endtask
endmodule // lhp_host_model
`default_nettype wire

// [lhp_host_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module lhp_host_port_test;
	import lhp_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mack = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, bclk, cs_n, bs_n, we0_n, we1_n, rd0_n, rw_n, oe_n, wait_n, panel;
	logic mreq, mwe, msel;
	logic [15:0] ha, hdi, hdo, mwd, capd, mrd = '0;
	logic [2:0] straps = 3'h7;
	logic [1:0] mbe, ep = 2'h2;
	logic [14:0] mwa;
	logic [18:0] cap;
	int n_errors = 0, n_tests = 0, lat = 0, cnt = 0;
	lhp_host_port DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .host_bus_clock(bclk), .chip_select_n(cs_n), .bus_status_strobe_n(bs_n),
		.low_byte_write_strobe_n(we0_n), .high_byte_write_strobe_n(we1_n),
		.low_byte_read_strobe_n(rd0_n), .read_write_n(rw_n), .host_addr(ha),
		.host_data_in(hdi), .host_data_out(hdo), .host_data_oe_n(oe_n), .host_wait_n(wait_n),
		.bus_mode_straps(straps), .endian_and_power_polarity_straps(ep),
		.panel_power_control(panel), .mem_req(mreq), .mem_we(mwe), .mem_word_addr(mwa),
		.mem_byte_en(mbe), .mem_wdata(mwd), .mem_reg_sel(msel), .mem_ack(mack), .mem_rdata(mrd));
	lhp_host_model host (.mclk, .bclk, .cs_n, .bs_n, .we0_n, .we1_n, .rd0_n, .rw_n,
		.addr(ha), .dout(hdi), .din(hdo), .oe_n, .wait_n);
	always #25 mclk = ~mclk;
	// back end acknowledges after lat cycles, to mimic refresh contention
	always @(posedge mclk) begin
		mack <= 1'b0;
		if (mreq && !mack) begin
			cnt <= cnt + 1;
			if (cnt >= lat) begin
				mack <= 1'b1;
				mrd <= 16'hA500 ^ {1'b0, mwa};
				cap <= {mwe, msel, mbe, mwa};
				capd <= mwd;
				cnt <= 0;
			end
		end
	end
	always @(posedge mclk) if (host.hung) begin
		n_errors++;
		final_report();
	end
	task final_report;
		if (n_errors == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [39:0] g, input logic [39:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (!pready && k < 20);
		if (!pready) begin
			n_errors++;
			final_report();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task do_reset(input logic [2:0] s, input logic [1:0] p, input logic sm);
		host.smode = sm;
		host.bs_n <= sm;
		straps <= s;
		ep <= p;
		rst <= 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		repeat (5) @(posedge mclk);
	endtask
	task t_regs;
		logic [31:0] r;
		logic e;
		do_reset(3'h7, 2'h2, 1'b0);
		chk(32'(panel), 32'h0);
		apb(1'b0, OFS_CTRL, 32'h0, r, e);
		chk(r, 32'h2);
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		chk(r, 32'h220);
		apb(1'b0, 8'h0C, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h3, r, e);
		repeat (2) @(posedge mclk);
		chk(32'(panel), 32'h1);
	endtask
	task t_gen;
		logic [31:0] r;
		logic e;
		logic [15:0] q;
		int wc;
		host.run(1'b1, 16'h0124, 2'h1, 16'hBEEF, 1'b1, q, wc);
		chk({cap, capd[7:0]}, 32'h48092EF);
		lat = 20;
		host.run(1'b1, 16'h0124, 2'h2, 16'hBEEF, 1'b1, q, wc);
		chk({cap, capd[15:8]}, 32'h50092BE);
		chk(32'(wc > 20), 32'h1);
		lat = 3;
		host.run(1'b0, 16'hFFE4, 2'h3, 16'h0000, 1'b1, q, wc);
		chk({cap, q}, 36'h3FFF2DAF2);
		host.run(1'b0, 16'h0124, 2'h2, 16'h0000, 1'b1, q, wc);
		chk(32'(cap), 32'h10092);
		apb(1'b0, OFS_XFER_CNT, 32'h0, r, e);
		chk(r, 32'h4);
		apb(1'b1, OFS_CTRL, 32'h0, r, e);
		host.run(1'b1, 16'h0124, 2'h3, 16'h1234, 1'b1, q, wc);
		chk(32'(wc), 32'h0);
	endtask
	task t_strobe;
		logic [31:0] r;
		logic e;
		logic [15:0] q;
		int wc;
		do_reset(3'h3, 2'h1, 1'b1);
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		chk(r, 32'h108);
		chk(32'(panel), 32'h1);
		lat = 5;
		host.run(1'b1, 16'h0124, 2'h1, 16'hBEEF, 1'b1, q, wc);
		chk({cap, capd[15:8]}, 32'h50092EF);
		host.run(1'b0, 16'h0124, 2'h3, 16'h0000, 1'b1, q, wc);
		chk({cap, q}, 36'h1809292A5);
		host.run(1'b1, 16'h0124, 2'h3, 16'h5678, 1'b0, q, wc);
		chk(32'(wc), 32'h0);
	endtask
	initial begin
		t_regs();
		t_gen();
		t_strobe();
		final_report();
	end
endmodule // lhp_host_port_test
`default_nettype wire
